/* File: bench/cies_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cies_core_test;
	import cies_pkg::*;
	typedef struct packed {
		logic [7:0] acc;
		logic z, kick, push, load, busy, disc;
		logic [14:0] st, tgt;
	} cies_exp_t;
	logic clock = 0, nrst = 0, instr_valid = 0, instr_dest = 0;
	cies_op_t instr_op = CIES_OP_NONE;
	logic [6:0] instr_addr = '0;
	logic [14:0] pc_in = '0;
	logic [7:0] upper_pc_latch = '0;
	logic [7:0] accum_r;
	logic null_result_flag_r, expiry_flag_n_r, sleep_flag_n_r;
	logic guard_timer_clear_r, prescaler_clear_r, push_r, pc_load_r;
	logic busy_r, discard_r;
	logic [14:0] stack_top_r, pc_target_r;
	logic [7:0] regs [0:127];
	logic [7:0] acc_m = '0;
	logic z_m = 0;
	integer seed = 32'h969d_9986, n_errors = 0, num_checks = 0, i;
	logic [31:0] rv;
	cies_exp_t q [$];
	cies_core i_cies_core (.clock(clock), .nrst(nrst),
		.instr_valid(instr_valid), .instr_op(instr_op),
		.instr_addr(instr_addr), .instr_dest(instr_dest), .pc_in(pc_in),
		.upper_pc_latch(upper_pc_latch), .accum_r(accum_r),
		.null_result_flag_r(null_result_flag_r),
		.expiry_flag_n_r(expiry_flag_n_r), .sleep_flag_n_r(sleep_flag_n_r),
		.guard_timer_clear_r(guard_timer_clear_r),
		.prescaler_clear_r(prescaler_clear_r), .push_r(push_r),
		.stack_top_r(stack_top_r), .pc_load_r(pc_load_r),
		.pc_target_r(pc_target_r), .busy_r(busy_r), .discard_r(discard_r));
	always #20 clock = ~clock;
	task automatic finish_test;
		if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [14:0] ex,
		input logic [14:0] sn);
		num_checks++;
		if (sn !== ex) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, ex, sn);
		end
	endtask
	// Model runs ahead of the design, one note per driven cycle
	task automatic drv(input cies_op_t op, input logic [6:0] a, input logic d);
		cies_exp_t e;
		logic [7:0] r;
		logic dead;
		e = '0;
		e.acc = acc_m;
		e.z = z_m;
		dead = 0;
		pc_in = 15'($random(seed));
		upper_pc_latch = 8'($random(seed));
		case (op)
		CIES_OP_KICK: e.kick = 1;
		CIES_OP_CALL_VIA_ACCUMULATOR: begin
			e.push = 1;
			e.load = 1;
			e.busy = 1;
			e.st = pc_in + PC_ONE;
			e.tgt = {upper_pc_latch[6:0], acc_m};
			dead = 1;
		end
		CIES_OP_ZERO_REG: begin
			regs[a] = ZERO_BYTE;
			e.z = 1;
		end
		CIES_OP_ACC_CLEAR: begin
			e.acc = ZERO_BYTE;
			e.z = 1;
		end
		CIES_OP_INVERT, CIES_OP_DEC, CIES_OP_DEC_SKIP: begin
			r = (op == CIES_OP_INVERT) ? ~regs[a] : regs[a] - ONE_BYTE;
			if (d == DEST_ACC) e.acc = r;
			else regs[a] = r;
			if (op != CIES_OP_DEC_SKIP) e.z = (r == ZERO_BYTE);
			else if (r == ZERO_BYTE) begin
				e.disc = 1;
				e.busy = 1;
				dead = 1;
			end
		end
		default: ;
		endcase
		acc_m = e.acc;
		z_m = e.z;
		instr_valid = 1;
		instr_op = op;
		instr_addr = a;
		instr_dest = d;
		q.push_back(e);
		@(posedge clock);
		#1;
		if (dead) begin
			// Offer a clear in the dead cycle; it must be ignored
			instr_op = CIES_OP_ACC_CLEAR;
			e.kick = 0;
			e.push = 0;
			e.load = 0;
			e.busy = 0;
			e.disc = 0;
			q.push_back(e);
			@(posedge clock);
			#1;
		end
	endtask
	initial forever begin
		cies_exp_t e;
		@(posedge clock);
		#0.5;
		if (q.size() > 0) begin
			e = q.pop_front();
			chk("accum", e.acc, accum_r);
			chk("null", e.z, null_result_flag_r);
			chk("wdclr", e.kick, guard_timer_clear_r);
			chk("psclr", e.kick, prescaler_clear_r);
			chk("flags", 2'b11, {expiry_flag_n_r, sleep_flag_n_r});
			chk("push", e.push, push_r);
			chk("load", e.load, pc_load_r);
			chk("busy", e.busy, busy_r);
			chk("discard", e.disc, discard_r);
			if (e.push) begin
				chk("stack_top", e.st, stack_top_r);
				chk("pc_target", e.tgt, pc_target_r);
			end
		end
	end
	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clock);
		#1;
		nrst = 1;
		for (i = 0; i < 128; i++) drv(CIES_OP_ZERO_REG, i[6:0], 1'b1);
		drv(CIES_OP_KICK, 7'h00, 1'b0);
		drv(CIES_OP_CALL_VIA_ACCUMULATOR, 7'h00, 1'b0);
		drv(CIES_OP_CALL_VIA_ACCUMULATOR, 7'h00, 1'b0);
		// Walk one register down to 2, then hit zero both ways
		for (i = 0; i < 254; i++) drv(CIES_OP_DEC_SKIP, 7'h05, 1'b1);
		drv(CIES_OP_DEC, 7'h05, 1'b1);
		drv(CIES_OP_DEC_SKIP, 7'h05, 1'b0);
		drv(CIES_OP_DEC_SKIP, 7'h05, 1'b1);
		// Flag set and accumulator loaded, so the reset values show
		drv(CIES_OP_ZERO_REG, 7'h06, 1'b1);
		drv(CIES_OP_DEC_SKIP, 7'h06, 1'b0);
		// Mid-run reset; file contents survive it, no request pending
		instr_valid = 0;
		nrst = 0;
		acc_m = ZERO_BYTE;
		z_m = 0;
		repeat (2) @(posedge clock);
		#1;
		nrst = 1;
		drv(CIES_OP_KICK, 7'h00, 1'b0);
		for (i = 0; i < 3000; i++) begin
			rv = $random(seed);
			drv(cies_op_t'(rv[2:0]), rv[9:3], rv[10]);
		end
		instr_valid = 0;
		for (i = 0; i < 10 && q.size() > 0; i++) @(posedge clock);
		if (q.size() > 0) n_errors++;
		finish_test();
	end
endmodule // cies_core_test
`default_nettype wire

/* File: common/cies_pkg.sv */
package cies_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 15;
	localparam int REGS = 128;
	localparam int PCL_W = 8;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [14:0] PC_ONE = 15'h0001;
	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam logic DEST_ACC = 1'b0;
	typedef enum logic [2:0] {
		CIES_OP_NONE,
		CIES_OP_KICK,
		CIES_OP_CALL_VIA_ACCUMULATOR,
		CIES_OP_INVERT,
		CIES_OP_ZERO_REG,
		CIES_OP_DEC,
		CIES_OP_ACC_CLEAR,
		CIES_OP_DEC_SKIP
	} cies_op_t;
	typedef enum logic [1:0] {
		CIES_ST_EXEC,
		CIES_ST_CALL2,
		CIES_ST_FLUSH
	} cies_state_t;
endpackage

/* File: hdl/cies_core.sv */
// Overview of operation
// (RQ1) Kick zeroes guard timer, sets expiry, sleep flags
// (RQ2) Kick also zeroes the guard timer prescaler
// (RQ3) Call via accumulator pushes PC plus one
// (RQ4) Then accumulator to PC low, latch high
// (RQ5) Call takes two cycles, flags untouched
// (RQ6) Invert complements register, dest selects target
// (RQ7) Zero register op clears register, sets null
// (RQ8) Decrement subtracts one, dest selects target
// (RQ9) Accumulator clear loads zero, sets null
// (RQ10) Decrement skip routes result, flags untouched
// (RQ11) Zero result discards next, runs no-operation
// (RQ12) Invert, decrement set null flag from result
// (RQ13) Discarded instruction becomes no-operation cycle
`timescale 1ns/1ps
`default_nettype none
module cies_core (
	input wire logic clock,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire cies_pkg::cies_op_t instr_op,
	input wire logic [cies_pkg::ADDR_W-1:0] instr_addr,
	input wire logic instr_dest,
	input wire logic [cies_pkg::PC_W-1:0] pc_in,
	input wire logic [cies_pkg::DATA_W-1:0] upper_pc_latch,
	output logic [cies_pkg::DATA_W-1:0] accum_r,
	output logic null_result_flag_r,
	output logic expiry_flag_n_r,
	output logic sleep_flag_n_r,
	output logic guard_timer_clear_r,
	output logic prescaler_clear_r,
	output logic push_r,
	output logic [cies_pkg::PC_W-1:0] stack_top_r,
	output logic pc_load_r,
	output logic [cies_pkg::PC_W-1:0] pc_target_r,
	output logic busy_r,
	output logic discard_r
);
	import cies_pkg::*;
	logic [DATA_W-1:0] file_r [REGS];
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] dec_val;
	cies_state_t state_r;
	logic take;
	assign take = instr_valid && state_r == CIES_ST_EXEC;
	assign operand = file_r[instr_addr];
	assign dec_val = operand - ONE_BYTE;

	// Sequencer; second cycle is dead time for call or skip
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= CIES_ST_EXEC;
		end else begin
			unique case (state_r)
			CIES_ST_EXEC: begin
				if (take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR) begin
					state_r <= CIES_ST_CALL2; // RQ5
				end else if (take && instr_op == CIES_OP_DEC_SKIP
					&& dec_val == ZERO_BYTE) begin
					state_r <= CIES_ST_FLUSH; // RQ11 RQ13
				end
			end
			CIES_ST_CALL2: state_r <= CIES_ST_EXEC;
			CIES_ST_FLUSH: state_r <= CIES_ST_EXEC;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			discard_r <= 1'b0;
		end else begin
			busy_r <= take && (instr_op == CIES_OP_CALL_VIA_ACCUMULATOR ||
				(instr_op == CIES_OP_DEC_SKIP && dec_val == ZERO_BYTE));
			// Fetched word is dropped; a no-op cycle runs instead
			discard_r <= take && instr_op == CIES_OP_DEC_SKIP
				&& dec_val == ZERO_BYTE; // RQ11 RQ13
		end
	end

	// Data file; no reset since software initialises it
	always_ff @(posedge clock) begin
		if (take && instr_dest != DEST_ACC) begin
			unique case (instr_op)
			CIES_OP_INVERT: file_r[instr_addr] <= ~operand; // RQ6
			CIES_OP_DEC: file_r[instr_addr] <= dec_val; // RQ8
			CIES_OP_DEC_SKIP: file_r[instr_addr] <= dec_val; // RQ10
			default: ;
			endcase
		end
		if (take && instr_op == CIES_OP_ZERO_REG) begin
			file_r[instr_addr] <= ZERO_BYTE; // RQ7
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			accum_r <= ZERO_BYTE;
		end else if (take) begin
			unique case (instr_op)
			CIES_OP_INVERT:
				if (instr_dest == DEST_ACC) accum_r <= ~operand; // RQ6
			CIES_OP_DEC:
				if (instr_dest == DEST_ACC) accum_r <= dec_val; // RQ8
			CIES_OP_DEC_SKIP:
				if (instr_dest == DEST_ACC) accum_r <= dec_val; // RQ10
			CIES_OP_ACC_CLEAR: accum_r <= ZERO_BYTE; // RQ9
			default: ;
			endcase
		end
	end

	// Zero flag; call and skip-decrement leave it alone
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			null_result_flag_r <= 1'b0;
		end else if (take) begin
			unique case (instr_op)
			CIES_OP_ZERO_REG: null_result_flag_r <= 1'b1; // RQ7
			CIES_OP_ACC_CLEAR: null_result_flag_r <= 1'b1; // RQ9
			CIES_OP_INVERT:
				null_result_flag_r <= (~operand == ZERO_BYTE); // RQ12
			CIES_OP_DEC:
				null_result_flag_r <= (dec_val == ZERO_BYTE); // RQ12
			default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			expiry_flag_n_r <= 1'b1;
			sleep_flag_n_r <= 1'b1;
			guard_timer_clear_r <= 1'b0;
			prescaler_clear_r <= 1'b0;
		end else begin
			guard_timer_clear_r <= take && instr_op == CIES_OP_KICK; // RQ1
			prescaler_clear_r <= take && instr_op == CIES_OP_KICK; // RQ2
			if (take && instr_op == CIES_OP_KICK) begin
				expiry_flag_n_r <= 1'b1; // RQ1
				sleep_flag_n_r <= 1'b1; // RQ1
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			push_r <= 1'b0;
			pc_load_r <= 1'b0;
			stack_top_r <= PC_RESET;
			pc_target_r <= PC_RESET;
		end else begin
			push_r <= take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR; // RQ3
			pc_load_r <= take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR; // RQ4
			if (take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR) begin
				stack_top_r <= pc_in + PC_ONE; // RQ3
				pc_target_r <= {upper_pc_latch[PC_W-PCL_W-1:0],
					accum_r}; // RQ4
			end
		end
	end

	chk_kick_flags: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_KICK |=> expiry_flag_n_r
		&& sleep_flag_n_r && guard_timer_clear_r && prescaler_clear_r)
		else $error("kick did not clear timer and set flags"); // RQ1
	chk_kick_pulse: assert property (@(posedge clock) disable iff (!nrst)
		prescaler_clear_r |-> $past(instr_op) == CIES_OP_KICK)
		else $error("prescaler clear without kick"); // RQ2
	chk_call_push: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR |=> push_r
		&& stack_top_r == $past(pc_in) + PC_ONE)
		else $error("call pushed wrong return address"); // RQ3
	chk_call_target: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR |=> pc_load_r
		&& pc_target_r[PCL_W-1:0] == $past(accum_r))
		else $error("call target low byte wrong"); // RQ4
	chk_call_upper: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR |=> pc_target_r[PC_W-1:PCL_W]
		== $past(upper_pc_latch[PC_W-PCL_W-1:0]))
		else $error("call target high bits wrong"); // RQ4
	chk_call_cycles: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_CALL_VIA_ACCUMULATOR |=> !take
		&& $stable(null_result_flag_r) ##1 $stable(null_result_flag_r))
		else $error("call not two cycles or flag moved"); // RQ5
	chk_zero_sets: assert property (@(posedge clock) disable iff (!nrst)
		take && (instr_op == CIES_OP_ZERO_REG ||
		instr_op == CIES_OP_ACC_CLEAR) |=> null_result_flag_r)
		else $error("clear did not set zero flag"); // RQ7
	chk_acc_clear: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_ACC_CLEAR |=> accum_r == ZERO_BYTE)
		else $error("accumulator not cleared"); // RQ9
	chk_dec_acc: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_DEC && instr_dest == DEST_ACC
		|=> accum_r == $past(operand) - ONE_BYTE)
		else $error("decrement to accumulator wrong"); // RQ8
	chk_inv_acc: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_INVERT && instr_dest == DEST_ACC
		|=> accum_r == ~$past(operand)
		&& null_result_flag_r == (accum_r == ZERO_BYTE))
		else $error("invert result or flag wrong"); // RQ6 RQ12
	chk_skip_flags: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_DEC_SKIP |=> $stable(
		null_result_flag_r))
		else $error("skip decrement changed flag"); // RQ10
	chk_skip_flush: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_DEC_SKIP && dec_val == ZERO_BYTE
		|=> discard_r && !take ##1 state_r == CIES_ST_EXEC)
		else $error("zero result did not discard next"); // RQ11 RQ13
	chk_skip_keep: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_DEC_SKIP && dec_val != ZERO_BYTE
		|=> !discard_r && !busy_r && state_r == CIES_ST_EXEC)
		else $error("non-zero result dropped next"); // RQ11
	chk_zero_reg: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_ZERO_REG
		|=> file_r[$past(instr_addr)] == ZERO_BYTE)
		else $error("register not cleared"); // RQ7
	chk_inv_reg: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_INVERT && instr_dest != DEST_ACC
		|=> file_r[$past(instr_addr)] == ~$past(operand))
		else $error("invert to register wrong"); // RQ6
	chk_dec_flag: assert property (@(posedge clock) disable iff (!nrst)
		take && instr_op == CIES_OP_DEC
		|=> null_result_flag_r == ($past(operand) == ONE_BYTE))
		else $error("decrement zero flag wrong"); // RQ12
endmodule // cies_core
`default_nettype wire
